// *** tick_watchdog_irq_pkg.sv ***
/*
 * Shared constants for the tick counter, prescaler, watchdog, sleep and
 * interrupt control block: register indices, field positions, reset values
 * and timing figures.
 * Assumes a 25 MHz instruction clock and an RC watchdog oscillator whose
 * nominal rate is given below.
 */
// How it works
// - Interrupt status upper four bits always read zero.
// - Timer1 match sets timer1_match_flag, bit 3; software clears it.
// - Serial transfer done sets serial_done_flag, bit 2; software clears it.
// - Falling edge on ext_irq_pin_n sets ext_irq_flag, bit 1.
// - Tick counter overflow sets tick_overflow_flag, bit 0.
// - Writes to interrupt status can only clear flags, never set them.
// - Reading interrupt status returns flags ANDed with the mask.
// - A source requests only when its mask bit and global_irq_en are both set; mask bits 7..4 unused.
// - global_irq_en ignores control writes; set by enable/return, cleared by disable.
// - Core control bits 3..0 and 7 read/write; bits 5 and 4 read zero.
// - The prescaler serves tick counter when assign is 0, watchdog when 1.
// - 8-bit prescaler; code n divides tick by 2^(n+1), watchdog by 2^n.
// - Writing tick counter clears the prescaler when assigned to it.
// - Watchdog clear or sleep clears watchdog and its assigned prescaler.
// - Tick counter is 8 bits; counts every instruction cycle unscaled when the prescaler is on the watchdog.
// - An enabled watchdog time-out resets the device, awake or asleep.
// - Watchdog counts on its own RC oscillator, also while asleep.
// - watchdog_run_en enables the watchdog only when watchdog_fuse is 1.
// - Unscaled watchdog time-out is about 18 ms of the RC time base.
// - Wake falling edge sets osc_run_ctrl; its fall stops, its rise restarts oscillator.
// - Every wake-up runs the start-up timer; fuse 1 re-enables the watchdog.
// - wake_function_disable at 0 enables pin wake-up, at 1 disables it.
// - timeout_flag set by sleep, watchdog clear and power-up; cleared by time-out.
// - powerdown_flag set at power-up and watchdog clear; cleared by sleep.
`default_nettype none

package tick_watchdog_irq_pkg;

	// Register word indices; byte address is four times the index
	localparam logic [5:0] IDX_TICK_COUNTER = 6'h01;
	localparam logic [5:0] IDX_CORE_CONTROL = 6'h02;
	localparam logic [5:0] IDX_RESET_STATUS = 6'h03;
	localparam logic [5:0] IDX_WATCHDOG_SLEEP = 6'h0e;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h0f;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h3f;

	// Field positions and writable masks
	localparam int FLAG_W = 4;
	localparam int FLAG_TICK = 0;
	localparam int FLAG_EXT = 1;
	localparam int FLAG_SERIAL = 2;
	localparam int FLAG_TIMER1 = 3;
	localparam int CC_GLOBAL_IRQ = 6;
	localparam int CC_PULLUP_DIS = 7;
	localparam int CC_ASSIGN = 3;
	localparam int CC_RATIO_LO = 0;
	localparam logic [7:0] CC_RW_MASK = 8'h8f;
	localparam int WSC_WAKE_DIS = 0;
	localparam int WSC_ROPTION = 3;
	localparam int WSC_OSC_RUN = 4;
	localparam int WSC_RUN_EN = 5;
	localparam int WSC_OPEN_DRAIN = 6;
	localparam logic [7:0] WSC_RW_MASK = 8'h79;
	localparam int RS_POWERDOWN = 3;
	localparam int RS_TIMEOUT = 4;

	// Reset values
	localparam logic [7:0] CC_RESET = 8'h00;
	localparam logic [7:0] WSC_RESET = 8'h10;
	localparam logic [7:0] TICK_RESET = 8'h00;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// Timing: watchdog period in its own unit and RC base rate
	localparam int CLK_HZ = 25_000_000;
	localparam int WDT_TIMEOUT_US = 18_000;
	localparam int WDT_OSC_KHZ = 1_000;
	localparam int WDT_TIMEOUT_TICKS_DEF = WDT_TIMEOUT_US * WDT_OSC_KHZ / 1_000;
	localparam int STARTUP_CYCLES_DEF = 512;

	// Power state of the core
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_DEEP_SLEEP = 2'b10,
		ST_STARTUP = 2'b11
	} power_state_e;

endpackage : tick_watchdog_irq_pkg

`default_nettype wire

// *** pin_sync_edge.sv ***
/*
 * Two-flop synchroniser with edge detection for one asynchronous level.
 * Assumes the input changes slower than half the clock rate.
 */
`default_nettype none

module pin_sync_edge #(
	parameter logic IDLE = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic level,
	output logic rise,
	output logic fall
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Only the second stage and later are looked at
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= IDLE;
			sync_q <= IDLE;
			prev_q <= IDLE;
		end
		else
		begin
			meta_q <= din;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges pulse for one cycle, in the same cycle the synchronised level changes
	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;

endmodule // pin_sync_edge

`default_nettype wire

// *** tick_watchdog_irq_ctrl.sv ***
/*
 * Tick counter, shared prescaler, watchdog, sleep/oscillator control and
 * interrupt flag/mask registers behind an Avalon-MM slave with one wait state.
 * Assumes the instruction decoder pulses the op inputs for one cycle, that
 * timer1_match and serial_done are one-cycle pulses on clk, and that the
 * system drives rst from watchdog_reset.
 */
// The Avalon-MM slave port was chosen for this implementation.
`default_nettype none

module tick_watchdog_irq_ctrl
	import tick_watchdog_irq_pkg::*;
#(
	parameter int WDT_TIMEOUT_COUNT = WDT_TIMEOUT_TICKS_DEF,
	parameter int WDT_W = 16,
	parameter int STARTUP_COUNT = STARTUP_CYCLES_DEF,
	parameter int STARTUP_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic [3:0] byteenable,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic disable_irq_op,
	input wire logic enable_irq_op,
	input wire logic return_irq_op,
	input wire logic watchdog_clear_op,
	input wire logic sleep_op,
	input wire logic timer1_match,
	input wire logic serial_done,
	input wire logic ext_irq_pin_n,
	input wire logic wake_pin_n,
	input wire logic wdt_osc,
	input wire logic watchdog_fuse,
	output logic irq_request,
	output logic global_irq_en,
	output logic watchdog_reset,
	output logic core_run,
	output logic osc_enable,
	output logic pullup_disable,
	output logic open_drain_en,
	output logic roption_en
);

	logic ack_q;
	logic [31:0] readdata_q;
	logic [FLAG_W-1:0] flags_q;
	logic [FLAG_W-1:0] flags_d;
	logic [FLAG_W-1:0] mask_q;
	logic [7:0] cc_q;
	logic gie_q;
	logic [7:0] wsc_q;
	logic [7:0] wsc_d;
	logic [7:0] tick_q;
	logic [7:0] psc_q;
	logic [WDT_W-1:0] wdt_q;
	logic wdt_rst_q;
	logic timeout_q;
	logic powerdown_q;
	logic [STARTUP_W-1:0] startup_cnt_q;
	power_state_e state_q;
	power_state_e state_d;

	// Pin inputs cross into clk through two flops each
	logic ext_fall;
	logic wake_fall;
	logic osc_rise;

	pin_sync_edge #(.IDLE(1'b1)) u_ext (
		.clk(clk),
		.rst(rst),
		.din(ext_irq_pin_n),
		.level(),
		.rise(),
		.fall(ext_fall)
	);

	pin_sync_edge #(.IDLE(1'b1)) u_wake (
		.clk(clk),
		.rst(rst),
		.din(wake_pin_n),
		.level(),
		.rise(),
		.fall(wake_fall)
	);

	pin_sync_edge #(.IDLE(1'b0)) u_wdt_osc (
		.clk(clk),
		.rst(rst),
		.din(wdt_osc),
		.level(),
		.rise(osc_rise),
		.fall()
	);

	// Bus decode; a write lands at the edge where waitrequest is low
	wire req = read | write;
	wire [5:0] idx = address[7:2];
	wire wr_fire = write & ack_q & byteenable[0];
	wire [7:0] wdat = writedata[7:0];
	wire wr_tick = wr_fire & (idx == IDX_TICK_COUNTER);
	wire wr_cc = wr_fire & (idx == IDX_CORE_CONTROL);
	wire wr_wsc = wr_fire & (idx == IDX_WATCHDOG_SLEEP);
	wire wr_mask = wr_fire & (idx == IDX_IRQ_MASK);
	wire wr_status = wr_fire & (idx == IDX_IRQ_STATUS);
	assign waitrequest = req & ~ack_q;

	// Read multiplexer; unmapped indices read zero
	wire [7:0] rd_status = {4'h0, flags_q & mask_q};
	wire [7:0] rd_cc = (cc_q & CC_RW_MASK) | (8'(gie_q) << CC_GLOBAL_IRQ);
	wire [7:0] rd_rs = (8'(timeout_q) << RS_TIMEOUT) | (8'(powerdown_q) << RS_POWERDOWN);
	wire [7:0] rd_mux =
		(idx == IDX_IRQ_STATUS) ? rd_status :
		(idx == IDX_CORE_CONTROL) ? rd_cc :
		(idx == IDX_TICK_COUNTER) ? tick_q :
		(idx == IDX_RESET_STATUS) ? rd_rs :
		(idx == IDX_WATCHDOG_SLEEP) ? (wsc_q & WSC_RW_MASK) :
		(idx == IDX_IRQ_MASK) ? {4'h0, mask_q} : 8'h00;

	// Prescaler routing and tap selection
	wire running = (state_q == ST_RUN);
	wire to_wdt = cc_q[CC_ASSIGN];
	wire [2:0] ratio = cc_q[CC_RATIO_LO +: 3];
	wire [8:0] tick_mask9 = (9'h002 << ratio) - 9'h001;
	wire [8:0] wdt_mask9 = (9'h001 << ratio) - 9'h001;
	wire [7:0] tick_mask = tick_mask9[7:0];
	wire [7:0] wdt_mask = wdt_mask9[7:0];
	wire psc_src = to_wdt ? osc_rise : running;
	wire psc_tap = to_wdt ? ((psc_q & wdt_mask) == wdt_mask) :
		((psc_q & tick_mask) == tick_mask);
	wire psc_fire = psc_src & psc_tap;
	wire wdt_clear = watchdog_clear_op | sleep_op;
	wire psc_clear = (wr_tick & ~to_wdt) | (wdt_clear & to_wdt);

	// Tick counter steps every running cycle, or on prescaler output
	wire tick_inc = to_wdt ? running : psc_fire;
	wire tick_wrap = tick_inc & (tick_q == 8'hff);

	// Watchdog steps on RC edges, or on prescaler output
	wire wdt_en = watchdog_fuse & wsc_q[WSC_RUN_EN];
	wire wdt_inc = wdt_en & (to_wdt ? psc_fire : osc_rise);
	wire wdt_last = (wdt_q == WDT_W'(WDT_TIMEOUT_COUNT - 1));
	wire wdt_timeout = wdt_inc & wdt_last & ~wdt_clear;

	// Hardware events that raise interrupt flags
	wire [FLAG_W-1:0] flag_set = {timer1_match, serial_done, ext_fall, tick_wrap};

	// Wake and oscillator transitions
	wire wake_ev = wake_fall & ~wsc_q[WSC_WAKE_DIS];
	wire osc_fall = wsc_q[WSC_OSC_RUN] & ~wsc_d[WSC_OSC_RUN];
	wire osc_up = ~wsc_q[WSC_OSC_RUN] & wsc_d[WSC_OSC_RUN];
	wire startup_done = (startup_cnt_q == STARTUP_W'(STARTUP_COUNT - 1));

	// Writes only clear; a set in the same cycle wins
	always_comb
	begin
		flags_d = wr_status ? (flags_q & wdat[FLAG_W-1:0]) : flags_q;
		flags_d = flags_d | flag_set;
	end

	// Watchdog/sleep control; hardware set of osc_run_ctrl wins over a clear
	always_comb
	begin
		wsc_d = wr_wsc ? (wdat & WSC_RW_MASK) : wsc_q;
		if (wake_ev)
		begin
			wsc_d[WSC_OSC_RUN] = 1'b1;
		end
		if (watchdog_fuse && ((state_q == ST_SLEEP && wake_ev) ||
			(state_q == ST_DEEP_SLEEP && wsc_d[WSC_OSC_RUN] && !wsc_q[WSC_OSC_RUN])))
		begin
			wsc_d[WSC_RUN_EN] = 1'b1;
		end
	end

	// Power state transitions
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
			begin
				if (osc_fall)
					state_d = ST_DEEP_SLEEP;
				else if (sleep_op)
					state_d = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				if (wake_ev)
					state_d = ST_STARTUP;
				else if (osc_fall)
					state_d = ST_DEEP_SLEEP;
			end
			ST_DEEP_SLEEP:
			begin
				if (wake_ev | osc_up)
					state_d = ST_STARTUP;
			end
			ST_STARTUP:
			begin
				if (startup_done)
					state_d = ST_RUN;
			end
			default:
			begin
				state_d = ST_RUN;
			end
		endcase
	end

	// Bus handshake and read data capture
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ack_q <= 1'b0;
			readdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (read & ~ack_q)
				readdata_q <= {24'h00_0000, rd_mux};
		end
	end

	// Interrupt flags and mask
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flags_q <= '0;
			mask_q <= MASK_RESET;
		end
		else
		begin
			flags_q <= flags_d;
			if (wr_mask)
				mask_q <= wdat[FLAG_W-1:0];
		end
	end

	// Core control; the global enable follows only the ops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cc_q <= CC_RESET;
			gie_q <= 1'b0;
		end
		else
		begin
			if (wr_cc)
				cc_q <= wdat & CC_RW_MASK;
			if (enable_irq_op | return_irq_op)
				gie_q <= 1'b1;
			else if (disable_irq_op)
				gie_q <= 1'b0;
		end
	end

	// Watchdog/sleep control register and power state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wsc_q <= WSC_RESET;
			state_q <= ST_RUN;
		end
		else
		begin
			wsc_q <= wsc_d;
			state_q <= state_d;
		end
	end

	// Oscillator start-up timer restarts on every entry to start-up
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			startup_cnt_q <= '0;
		else if (state_q != ST_STARTUP || startup_done)
			startup_cnt_q <= '0;
		else
			startup_cnt_q <= startup_cnt_q + STARTUP_W'(1);
	end

	// Prescaler and tick counter; a tick write beats the increment
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			psc_q <= 8'h00;
			tick_q <= TICK_RESET;
		end
		else
		begin
			if (psc_clear)
				psc_q <= 8'h00;
			else if (psc_src)
				psc_q <= psc_q + 8'h01;
			if (wr_tick)
				tick_q <= wdat;
			else if (tick_inc)
				tick_q <= tick_q + 8'h01;
		end
	end

	// Watchdog counter and reset pulse; held at zero while disabled
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wdt_q <= '0;
			wdt_rst_q <= 1'b0;
		end
		else
		begin
			wdt_rst_q <= wdt_timeout;
			if (wdt_clear | ~wdt_en | wdt_timeout)
				wdt_q <= '0;
			else if (wdt_inc)
				wdt_q <= wdt_q + WDT_W'(1);
		end
	end

	// Reset cause flags; power-up sets both
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			timeout_q <= 1'b1;
			powerdown_q <= 1'b1;
		end
		else
		begin
			if (wdt_timeout)
				timeout_q <= 1'b0;
			else if (sleep_op | watchdog_clear_op)
				timeout_q <= 1'b1;
			if (watchdog_clear_op)
				powerdown_q <= 1'b1;
			else if (sleep_op)
				powerdown_q <= 1'b0;
		end
	end

	// Outputs; the request is gated by mask and global enable
	assign readdata = readdata_q;
	assign irq_request = gie_q & (|(flags_q & mask_q));
	assign global_irq_en = gie_q;
	assign watchdog_reset = wdt_rst_q;
	assign core_run = running;
	assign osc_enable = (state_q != ST_DEEP_SLEEP);
	assign pullup_disable = cc_q[CC_PULLUP_DIS];
	assign open_drain_en = wsc_q[WSC_OPEN_DRAIN];
	assign roption_en = wsc_q[WSC_ROPTION];

endmodule // tick_watchdog_irq_ctrl

`default_nettype wire

// *** tick_watchdog_irq_props.sv ***
/*
 * Checker for the tick, watchdog and interrupt control block.
 * Assumes op inputs are one-cycle pulses and the fuse changes rarely.
 */
`default_nettype none

module tick_watchdog_irq_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] address,
	input wire logic [3:0] byteenable,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic disable_irq_op,
	input wire logic enable_irq_op,
	input wire logic return_irq_op,
	input wire logic watchdog_fuse,
	input wire logic global_irq_en,
	input wire logic watchdog_reset,
	input wire logic core_run,
	input wire logic osc_enable,
	input wire logic pullup_disable
);
	// All checks share one clock and the power-up reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_status_hi;
		read && !waitrequest && address == 8'hfc |-> readdata[31:4] == 28'h0;
	endproperty
	a_status_hi: assert property (p_status_hi) else $error("status upper bits set");
	property p_cc_zero;
		read && !waitrequest && address == 8'h08 |-> readdata[5:4] == 2'b00;
	endproperty
	a_cc_zero: assert property (p_cc_zero) else $error("control bits 5:4 not zero");
	property p_pullup;
		write && byteenable[0] && !waitrequest && address == 8'h08 |=>
			pullup_disable == $past(writedata[7]);
	endproperty
	a_pullup: assert property (p_pullup) else $error("control bit 7 not stored");
	// Only the three ops may move the global enable; control writes cannot
	property p_gie_hold;
		!(enable_irq_op || return_irq_op || disable_irq_op) |=> $stable(global_irq_en);
	endproperty
	a_gie_hold: assert property (p_gie_hold) else $error("global enable moved alone");
	property p_gie_set;
		enable_irq_op || return_irq_op |=> global_irq_en;
	endproperty
	a_gie_set: assert property (p_gie_set) else $error("global enable not set");
	property p_gie_clr;
		disable_irq_op && !enable_irq_op && !return_irq_op |=> !global_irq_en;
	endproperty
	a_gie_clr: assert property (p_gie_clr) else $error("global enable not cleared");
	property p_no_wdt;
		!watchdog_fuse ##1 !watchdog_fuse |-> !watchdog_reset;
	endproperty
	a_no_wdt: assert property (p_no_wdt) else $error("watchdog fired with fuse off");
	// Start-up timer must hold the core with the oscillator running
	property p_startup;
		$rose(core_run) |-> !$past(core_run, 3) && $past(osc_enable, 1) && $past(osc_enable, 3);
	endproperty
	a_startup: assert property (p_startup) else $error("run resumed without start-up");
endmodule // tick_watchdog_irq_props

bind tick_watchdog_irq_ctrl tick_watchdog_irq_props tick_watchdog_irq_props_i (
	.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
	.byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.disable_irq_op(disable_irq_op), .enable_irq_op(enable_irq_op),
	.return_irq_op(return_irq_op), .watchdog_fuse(watchdog_fuse),
	.global_irq_en(global_irq_en), .watchdog_reset(watchdog_reset),
	.core_run(core_run), .osc_enable(osc_enable), .pullup_disable(pullup_disable)
);

`default_nettype wire

// *** tb_tick_watchdog_irq_ctrl.sv ***
/*
 * Self-checking bench for the tick, watchdog and interrupt control block.
 * Assumes short watchdog and start-up counts and a bus slave with waitrequest.
 */
`default_nettype none

module tb_tick_watchdog_irq_ctrl
	import tick_watchdog_irq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [4:0] ops = 5'h00; // disable, enable, return, watchdog clear, sleep
	logic timer1_match = 1'b0;
	logic serial_done = 1'b0;
	logic ext_n = 1'b1;
	logic wake_n = 1'b1;
	logic wdt_osc = 1'b0;
	logic fuse = 1'b0;
	logic [31:0] readdata;
	logic waitrequest, irq_request, global_irq_en, watchdog_reset, core_run, osc_enable;
	logic pullup_disable, open_drain_en, roption_en;
	logic [7:0] rv, t0;
	int err_count = 0;
	int compares = 0;
	int wdt_seen = 0;

	tick_watchdog_irq_ctrl #(.WDT_TIMEOUT_COUNT(8), .STARTUP_COUNT(4)) tick_watchdog_irq_ctrl_i (
		.clk(clk), .rst(rst), .address(address), .byteenable(4'h1), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.disable_irq_op(ops[0]), .enable_irq_op(ops[1]), .return_irq_op(ops[2]),
		.watchdog_clear_op(ops[3]), .sleep_op(ops[4]), .timer1_match(timer1_match),
		.serial_done(serial_done), .ext_irq_pin_n(ext_n), .wake_pin_n(wake_n),
		.wdt_osc(wdt_osc), .watchdog_fuse(fuse), .irq_request(irq_request),
		.global_irq_en(global_irq_en), .watchdog_reset(watchdog_reset), .core_run(core_run),
		.osc_enable(osc_enable), .pullup_disable(pullup_disable),
		.open_drain_en(open_drain_en), .roption_en(roption_en)
	);

	// Instruction clock, and an RC clock off the clock grid so phases drift
	always #20 clk = ~clk;
	always #170 wdt_osc = ~wdt_osc;
	always @(posedge clk) if (watchdog_reset === 1'b1) wdt_seen++;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One bus cycle; waitrequest and data are taken at the rising edge before it updates them
	task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		read <= !is_wr;
		write <= is_wr;
		address <= a;
		writedata <= {24'h0, d};
		do
		begin
			@(posedge clk);
		end
		while (waitrequest !== 1'b0);
		rv = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		access(1'b0, a, 8'h00);
		check(rv, e);
	endtask

	task automatic op(input int b);
		@(posedge clk);
		ops[b] <= 1'b1;
		@(posedge clk);
		ops[b] <= 1'b0;
	endtask

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Hang guard, well beyond the few thousand cycles the sequence needs
	initial
	begin
		#800000;
		err_count++;
		end_of_test();
	end

	// Main sequence: registers, interrupt flags, counters, watchdog, sleep
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdc(8'h08, CC_RESET);
		rdc(8'h38, WSC_RESET);
		rdc(8'h0c, 8'h18);
		// Pin-control bits of the watchdog/sleep register reach their outputs
		wr(8'h38, 8'h59);
		@(negedge clk);
		check({6'h0, open_drain_en, roption_en}, 8'h03);
		rdc(8'h38, 8'h59);
		wr(8'h38, WSC_RESET);
		wr(8'h40, 8'hff);
		rdc(8'h40, 8'h00);
		wr(8'h08, 8'hff);
		rdc(8'h08, 8'h8f);
		op(1);
		wr(8'h08, 8'h00);
		rdc(8'h08, 8'h40);
		op(0);
		rdc(8'h08, 8'h00);
		op(2);
		rdc(8'h08, 8'h40);
		wr(8'h3c, 8'h0a);
		@(posedge clk);
		timer1_match <= 1'b1;
		serial_done <= 1'b1;
		@(posedge clk);
		timer1_match <= 1'b0;
		serial_done <= 1'b0;
		rdc(8'hfc, 8'h08);
		@(negedge clk);
		check({7'h0, irq_request}, 8'h01);
		wr(8'h3c, 8'hff);
		rdc(8'h3c, 8'h0f);
		wr(8'hfc, 8'hff);
		rdc(8'hfc, 8'h0c);
		wr(8'hfc, 8'h04);
		rdc(8'hfc, 8'h04);
		wr(8'hfc, 8'h00);
		ext_n <= 1'b0;
		repeat (6) @(posedge clk);
		rdc(8'hfc, 8'h02);
		ext_n <= 1'b1;
		wr(8'hfc, 8'h00);
		// Prescaler on the watchdog leaves the tick counter unscaled
		wr(8'h08, 8'h08);
		wr(8'h04, 8'hfe);
		repeat (3) @(posedge clk);
		rdc(8'hfc, 8'h01);
		access(1'b0, 8'h04, 8'h00);
		t0 = rv;
		rdc(8'h04, t0 + 8'h03);
		// Each ratio: the read lands midway through the fourth prescaled period
		for (int n = 0; n < 8; n++)
		begin
			wr(8'h08, 8'(n));
			wr(8'h04, 8'h00);
			repeat ((7 << n) - 1) @(posedge clk);
			rdc(8'h04, 8'h03);
		end
		wr(8'h08, 8'h00);
		fuse <= 1'b1;
		wr(8'h38, 8'h30);
		repeat (200) @(posedge clk);
		check(8'(wdt_seen > 0), 8'h01);
		rdc(8'h0c, 8'h08);
		op(3);
		rdc(8'h0c, 8'h18);
		wdt_seen = 0;
		repeat (6)
		begin
			repeat (30) @(posedge clk);
			op(3);
		end
		check(8'(wdt_seen), 8'h00);
		fuse <= 1'b0;
		wdt_seen = 0;
		repeat (200) @(posedge clk);
		check(8'(wdt_seen), 8'h00);
		op(4);
		rdc(8'h0c, 8'h10);
		wr(8'h38, 8'h20);
		@(negedge clk);
		check({6'h0, osc_enable, core_run}, 8'h00);
		wake_n <= 1'b0;
		repeat (20) @(posedge clk);
		wake_n <= 1'b1;
		@(negedge clk);
		check({6'h0, osc_enable, core_run}, 8'h03);
		rdc(8'h38, 8'h30);
		// Wake pin disabled: only software can restart the oscillator
		wr(8'h38, 8'h21);
		wake_n <= 1'b0;
		repeat (20) @(posedge clk);
		wake_n <= 1'b1;
		@(negedge clk);
		check({6'h0, osc_enable, core_run}, 8'h00);
		wr(8'h38, 8'h31);
		repeat (10) @(posedge clk);
		check({7'h0, core_run}, 8'h01);
		end_of_test();
	end
endmodule // tb_tick_watchdog_irq_ctrl

`default_nettype wire
